// ### dwg_wavegen.sv
/*
 * DAC waveform generator top: APB register file, analog clock and DAC update tick generators,
 * source selection and the output registers toward the fast and the low power DAC.
 * Assumes a 250 MHz clock, an APB master of the usual kind, and DACs that latch on the update strobes.
 */
// Implementation choices: the placing of the registers and the APB register port.
// How it works
// - Generator runs only while the run bit in front end control is 1.
// - Selected source starts and loops until run cleared or source changed.
// - When stopped, DAC output holds until run set again, type set to sine or trapezoid, fast data written in direct mode, or reset.
// - Sine frequency is 16 MHz times 31-bit word over 2^30.
// - Starting the sine loads the phase accumulator with the offset register.
// - Phase accumulator only steps forward by the frequency word.
// - Six values shape the trapezoid: two levels, two delays, two slopes.
// - Zero slope durations switch levels at once, giving a square wave.
// - Trapezoid times count DAC update periods at 320 kHz.
// - Trapezoid period runs from first delay to end of second slope, repeating.
// - Samples go to either the fast DAC or the low power DAC.
// - Type field selects direct write (00), sine (10) or trapezoid (11).
module dwg_wavegen
   import dwg_pkg::*;
(
   // Clock and reset.
   input  wire logic              clk,
   input  wire logic              rst_b,
   // APB slave.
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // DAC side.
   output logic      [DAC_W-1:0]  fastDacCode,
   output logic                   fastDacUpdate,
   output logic      [DAC_W-1:0]  lpDacCode,
   output logic                   lpDacUpdate
);
   logic                runReg_reg, runReg_next;
   logic [5:0]          wavegen_config_reg_reg, wavegen_config_reg_next;
   logic [DAC_W-1:0]    lvl1_reg, lvl1_next, lvl2_reg, lvl2_next, fastData_reg, fastData_next;
   logic [TIME_W-1:0]   dly1_reg, dly1_next, slp1_reg, slp1_next, dly2_reg, dly2_next, slp2_reg, slp2_next;
   logic [FCW_W-1:0]    fcw_reg, fcw_next;
   logic [PHASE_W-1:0]  offset_reg, offset_next;
   logic                lpRoute_reg, lpRoute_next;
   logic                start_reg, start_next;

   logic                wrEn, wgconWr, feWr, dataWr, mapped;
   logic [1:0]          waveform_type_field;
   logic                genActive;

   assign wrEn    = psel && penable && pwrite;
   assign wgconWr = wrEn && (paddr == OFF_WG_CONFIG);
   assign feWr    = wrEn && (paddr == OFF_FRONT_END);
   assign dataWr  = wrEn && (paddr == OFF_FAST_DATA);
   assign waveform_type_field = wavegen_config_reg_reg[TYPE_LSB +: 2];
   assign genActive = runReg_reg && waveform_type_field[1];

   always_comb begin
      runReg_next  = runReg_reg;
      wavegen_config_reg_next   = wavegen_config_reg_reg;
      lvl1_next    = lvl1_reg;
      lvl2_next    = lvl2_reg;
      dly1_next    = dly1_reg;
      slp1_next    = slp1_reg;
      dly2_next    = dly2_reg;
      slp2_next    = slp2_reg;
      fcw_next     = fcw_reg;
      offset_next  = offset_reg;
      fastData_next = fastData_reg;
      lpRoute_next = lpRoute_reg;
      start_next   = 1'b0;
      if (wrEn) begin
         case (paddr)
            OFF_FRONT_END: begin
               runReg_next = pwdata[RUN_BIT];
               start_next  = pwdata[RUN_BIT] && !runReg_reg;
            end
            OFF_WG_CONFIG: begin
               wavegen_config_reg_next = {pwdata[GAIN_CAL_BIT], pwdata[OFFSET_CAL_BIT], 1'b0, pwdata[TYPE_LSB +: 2], 1'b0};
               // Choosing sine or trapezoid turns the generator on and restarts it from the top.
               if (pwdata[TYPE_LSB + 1]) begin
                  runReg_next = 1'b1;
                  start_next  = 1'b1;
               end
            end
            OFF_LEVEL_FIRST: lvl1_next    = pwdata[DAC_W-1:0];
            OFF_LEVEL_SECND: lvl2_next    = pwdata[DAC_W-1:0];
            OFF_DELAY_FIRST: dly1_next    = pwdata[TIME_W-1:0];
            OFF_SLOPE_FIRST: slp1_next    = pwdata[TIME_W-1:0];
            OFF_DELAY_SECND: dly2_next    = pwdata[TIME_W-1:0];
            OFF_SLOPE_SECND: slp2_next    = pwdata[TIME_W-1:0];
            OFF_FREQ_WORD:   fcw_next     = pwdata[FCW_W-1:0];
            OFF_SINE_OFFSET: offset_next  = pwdata[PHASE_W-1:0];
            OFF_FAST_DATA:   fastData_next = pwdata[DAC_W-1:0];
            OFF_LP_CONTROL:  lpRoute_next = pwdata[LP_ROUTE_BIT];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         runReg_reg   <= 1'b0;
         wavegen_config_reg_reg    <= WG_CONFIG_RST;
         lvl1_reg     <= '0;
         lvl2_reg     <= '0;
         dly1_reg     <= '0;
         slp1_reg     <= '0;
         dly2_reg     <= '0;
         slp2_reg     <= '0;
         fcw_reg      <= '0;
         offset_reg   <= '0;
         fastData_reg <= '0;
         lpRoute_reg  <= 1'b0;
         start_reg    <= 1'b0;
      end else begin
         runReg_reg   <= runReg_next;
         wavegen_config_reg_reg    <= wavegen_config_reg_next;
         lvl1_reg     <= lvl1_next;
         lvl2_reg     <= lvl2_next;
         dly1_reg     <= dly1_next;
         slp1_reg     <= slp1_next;
         dly2_reg     <= dly2_next;
         slp2_reg     <= slp2_next;
         fcw_reg      <= fcw_next;
         offset_reg   <= offset_next;
         fastData_reg <= fastData_next;
         lpRoute_reg  <= lpRoute_next;
         start_reg    <= start_next;
      end
   end

   // Neither rate divides the clock evenly, so a fractional accumulator spreads the ticks; the mean is exact.
   logic [RATE_W-1:0] aclkAcc_reg, aclkAcc_next, updAcc_reg, updAcc_next;
   logic              aclkTick, updTick;

   function automatic logic [RATE_W:0] fracStep(input logic [RATE_W-1:0] acc, input int inc);
      logic [RATE_W:0] sum;
      sum = {1'b0, acc} + (RATE_W+1)'(inc);
      if (sum >= (RATE_W+1)'(CLK_KHZ / 10)) begin
         return {1'b1, RATE_W'(sum - (RATE_W+1)'(CLK_KHZ / 10))};
      end
      return {1'b0, sum[RATE_W-1:0]};
   endfunction

   always_comb begin
      {aclkTick, aclkAcc_next} = fracStep(aclkAcc_reg, ACLK_KHZ / 10);
      {updTick, updAcc_next}   = fracStep(updAcc_reg, DAC_UPDATE_KHZ / 10);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aclkAcc_reg <= '0;
         updAcc_reg  <= '0;
      end else begin
         aclkAcc_reg <= aclkAcc_next;
         updAcc_reg  <= updAcc_next;
      end
   end

   logic [PHASE_W-1:0] sinePhase;
   logic [DAC_W-1:0]   sineSample, trapSample;
   logic               trapInSlope;

   dwg_sine_gen u_sine (
      .clk         (clk),
      .rst_b       (rst_b),
      .start       (start_reg),
      .run         (genActive && waveform_type_field == TYPE_SINE),
      .tick        (aclkTick),
      .freqWord    (fcw_reg),
      .phaseOffset (offset_reg),
      .phase       (sinePhase),
      .sample      (sineSample)
   );

   dwg_trap_gen u_trap (
      .clk         (clk),
      .rst_b       (rst_b),
      .start       (start_reg),
      .run         (genActive && waveform_type_field == TYPE_TRAP),
      .tick        (updTick),
      .levelFirst  (lvl1_reg),
      .levelSecond (lvl2_reg),
      .delayFirst  (dly1_reg),
      .slopeFirst  (slp1_reg),
      .delaySecond (dly2_reg),
      .slopeSecond (slp2_reg),
      .inSlope     (trapInSlope),
      .sample      (trapSample)
   );

   // Output registers: only a live source or a direct write moves them, so a stopped generator holds.
   logic [DAC_W-1:0] srcCode, fast_reg, fast_next, lp_reg, lp_next;
   logic             srcStrobe, fastUpd_reg, fastUpd_next, lpUpd_reg, lpUpd_next;

   always_comb begin
      srcCode   = (waveform_type_field == TYPE_SINE) ? sineSample : trapSample;
      // The restart cycle still shows the old source state, so a tick there is not passed on.
      srcStrobe = genActive && !start_reg && ((waveform_type_field == TYPE_SINE) ? aclkTick : updTick);
      if (waveform_type_field == TYPE_DIRECT) begin
         srcCode   = fastData_next;
         srcStrobe = dataWr;
      end
      fast_next    = fast_reg;
      lp_next      = lp_reg;
      fastUpd_next = 1'b0;
      lpUpd_next   = 1'b0;
      if (srcStrobe) begin
         if (lpRoute_reg) begin
            lp_next    = srcCode;
            lpUpd_next = 1'b1;
         end else begin
            fast_next    = srcCode;
            fastUpd_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fast_reg    <= '0;
         lp_reg      <= '0;
         fastUpd_reg <= 1'b0;
         lpUpd_reg   <= 1'b0;
      end else begin
         fast_reg    <= fast_next;
         lp_reg      <= lp_next;
         fastUpd_reg <= fastUpd_next;
         lpUpd_reg   <= lpUpd_next;
      end
   end

   assign fastDacCode   = fast_reg;
   assign lpDacCode     = lp_reg;
   assign fastDacUpdate = fastUpd_reg;
   assign lpDacUpdate   = lpUpd_reg;

   // APB answers with no wait state; an unmapped address reads zero and flags an error.
   always_comb begin
      mapped = 1'b1;
      prdata = 32'h0;
      case (paddr)
         OFF_FRONT_END:   prdata[RUN_BIT] = runReg_reg;
         OFF_WG_CONFIG:   prdata[5:0] = wavegen_config_reg_reg;
         OFF_LEVEL_FIRST: prdata[DAC_W-1:0] = lvl1_reg;
         OFF_LEVEL_SECND: prdata[DAC_W-1:0] = lvl2_reg;
         OFF_DELAY_FIRST: prdata[TIME_W-1:0] = dly1_reg;
         OFF_SLOPE_FIRST: prdata[TIME_W-1:0] = slp1_reg;
         OFF_DELAY_SECND: prdata[TIME_W-1:0] = dly2_reg;
         OFF_SLOPE_SECND: prdata[TIME_W-1:0] = slp2_reg;
         OFF_FREQ_WORD:   prdata[FCW_W-1:0] = fcw_reg;
         OFF_SINE_OFFSET: prdata[PHASE_W-1:0] = offset_reg;
         OFF_STATUS:      prdata = {4'h0, lp_reg, 3'h0, trapInSlope, fast_reg};
         OFF_FAST_DATA:   prdata[DAC_W-1:0] = fastData_reg;
         OFF_LP_CONTROL:  prdata[LP_ROUTE_BIT] = lpRoute_reg;
         default:         mapped = 1'b0;
      endcase
   end
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_RUN_GATES: assert property (!runReg_reg |-> !srcStrobe || waveform_type_field == TYPE_DIRECT)
      else $error("generator source advanced while stopped");
   AST_HOLD_STOPPED: assert property (!runReg_reg && !dataWr |=> $stable(fast_reg) && $stable(lp_reg))
      else $error("DAC output moved while generator stopped");
   AST_RUN_CLEAR: assert property (feWr |=> runReg_reg == $past(pwdata[RUN_BIT]))
      else $error("run bit does not follow the front end control write");
   AST_TYPE_STARTS: assert property (wgconWr && pwdata[TYPE_LSB + 1] |=> runReg_reg && start_reg
      ##1 runReg_reg)
      else $error("selecting a waveform did not start the generator");
   AST_PHASE_LOAD: assert property (start_reg |=> sinePhase == $past(offset_reg))
      else $error("phase accumulator not loaded from offset");
   AST_PHASE_FWD: assert property (!start_reg && aclkTick && genActive && waveform_type_field == TYPE_SINE
      |=> sinePhase == PHASE_W'($past(sinePhase) + $past(fcw_reg[PHASE_W-1:0])))
      else $error("phase step differs from frequency word");
   AST_ACLK_RATE: assert property (aclkTick |=> !aclkTick [*8])
      else $error("analog clock ticks too close");
   AST_UPD_RATE: assert property (updTick |=> !updTick [*8] ##1 !updTick [*8])
      else $error("DAC update ticks too close");
   AST_SQUARE: assert property (slp1_reg == '0 && slp2_reg == '0 && !start_reg |=> !trapInSlope)
      else $error("slope entered with zero slope durations");
   AST_ROUTE: assert property (srcStrobe && lpRoute_reg |=> lpDacUpdate && !fastDacUpdate
      && lp_reg == $past(srcCode))
      else $error("sample not delivered to the low power DAC");

   COV_SINE: cover property (genActive && waveform_type_field == TYPE_SINE && fastDacUpdate);
   COV_TRAP_SLOPE: cover property (genActive && trapInSlope ##1 !trapInSlope);
   COV_LP_ROUTE: cover property (lpDacUpdate);
   COV_DIRECT: cover property (dataWr && waveform_type_field == TYPE_DIRECT ##1 fastDacUpdate);
endmodule

// ### dwg_pkg.sv
/*
 * Shared constants for the DAC waveform generator: register byte offsets, field positions,
 * reset values, waveform type codes and the rate figures used to derive update ticks.
 * Assumes an APB slave with a 16-bit byte address and 32-bit data.
 */
package dwg_pkg;
   localparam int          ADDR_W          = 16;
   localparam int          DAC_W           = 12;
   localparam int          TIME_W          = 20;
   localparam int          FCW_W           = 31;
   localparam int          PHASE_W         = 30;
   // Register byte offsets.
   localparam logic [15:0] OFF_FRONT_END   = 16'h2000;
   localparam logic [15:0] OFF_WG_CONFIG   = 16'h2014;
   localparam logic [15:0] OFF_LEVEL_FIRST = 16'h2018;
   localparam logic [15:0] OFF_LEVEL_SECND = 16'h201c;
   localparam logic [15:0] OFF_DELAY_FIRST = 16'h2020;
   localparam logic [15:0] OFF_SLOPE_FIRST = 16'h2024;
   localparam logic [15:0] OFF_DELAY_SECND = 16'h2028;
   localparam logic [15:0] OFF_SLOPE_SECND = 16'h202c;
   localparam logic [15:0] OFF_FREQ_WORD   = 16'h2030;
   localparam logic [15:0] OFF_SINE_OFFSET = 16'h2038;
   localparam logic [15:0] OFF_STATUS      = 16'h2040;
   localparam logic [15:0] OFF_FAST_DATA   = 16'h2048;
   localparam logic [15:0] OFF_LP_CONTROL  = 16'h2050;
   // Field positions.
   localparam int          RUN_BIT         = 0;
   localparam int          TYPE_LSB        = 1;
   localparam int          OFFSET_CAL_BIT  = 4;
   localparam int          GAIN_CAL_BIT    = 5;
   localparam int          LP_ROUTE_BIT    = 6;
   localparam logic [5:0]  WG_CONFIG_RST   = 6'h30;
   // Waveform type codes.
   localparam logic [1:0]  TYPE_DIRECT     = 2'h0;
   localparam logic [1:0]  TYPE_SINE       = 2'h2;
   localparam logic [1:0]  TYPE_TRAP       = 2'h3;
   // Rates in kHz; ticks are spread over the system clock by a fractional accumulator.
   localparam int          CLK_KHZ         = 250000;
   localparam int          ACLK_KHZ        = 16000;
   localparam int          DAC_UPDATE_KHZ  = 320;
   localparam int          RATE_W          = 18;
   localparam logic [DAC_W-1:0] DAC_MID    = 12'h800;
   typedef enum logic [3:0] {
      DWG_DELAY1 = 4'h1,
      DWG_SLOPE1 = 4'h2,
      DWG_DELAY2 = 4'h4,
      DWG_SLOPE2 = 4'h8
   } dwg_trap_state_e;
endpackage

// ### dwg_sine_gen.sv
/*
 * Sine source: a phase accumulator stepped on each analog clock tick, followed by a quarter-wave table.
 * Assumes start and tick are one-cycle pulses from the register block on the same clock.
 */
module dwg_sine_gen
   import dwg_pkg::*;
(
   // Clock and reset.
   input  wire logic               clk,
   input  wire logic               rst_b,
   // Control.
   input  wire logic               start,
   input  wire logic               run,
   input  wire logic               tick,
   input  wire logic [FCW_W-1:0]   freqWord,
   input  wire logic [PHASE_W-1:0] phaseOffset,
   // Result.
   output logic      [PHASE_W-1:0] phase,
   output logic      [DAC_W-1:0]   sample
);
   logic [PHASE_W-1:0] phase_reg, phase_next;

   // Half-sample-centred quarter sine, amplitude 2047.
   function automatic logic [10:0] quarterSine(input logic [3:0] idx);
      logic [10:0] v;
      v = 11'h0;
      case (idx)
         4'h0: v = 11'h064;
         4'h1: v = 11'h12c;
         4'h2: v = 11'h1f1;
         4'h3: v = 11'h2b2;
         4'h4: v = 11'h36b;
         4'h5: v = 11'h41c;
         4'h6: v = 11'h4c3;
         4'h7: v = 11'h55f;
         4'h8: v = 11'h5ed;
         4'h9: v = 11'h66c;
         4'ha: v = 11'h6dc;
         4'hb: v = 11'h73a;
         4'hc: v = 11'h787;
         4'hd: v = 11'h7c2;
         4'he: v = 11'h7e9;
         default: v = 11'h7fd;
      endcase
      return v;
   endfunction

   always_comb begin
      phase_next = phase_reg;
      if (start) begin
         phase_next = phaseOffset;
      end else if (run && tick) begin
         // Bit 30 of the word adds a whole cycle, so dropping it keeps the 2^30 scaling exact.
         phase_next = phase_reg + freqWord[PHASE_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_reg <= '0;
      end else begin
         phase_reg <= phase_next;
      end
   end

   logic [3:0]  tabIdx;
   logic [10:0] mag;
   always_comb begin
      // The top bit picks the half wave, the next one mirrors the quarter, and the next four index the table.
      tabIdx = phase_reg[PHASE_W-2] ? ~phase_reg[PHASE_W-3 -: 4] : phase_reg[PHASE_W-3 -: 4];
      mag    = quarterSine(tabIdx);
      sample = phase_reg[PHASE_W-1] ? DAC_MID - {1'b0, mag} : DAC_MID + {1'b0, mag};
   end

   assign phase = phase_reg;
endmodule

// ### dwg_trap_gen.sv
/*
 * Trapezoid source: delay, slope, delay, slope, looped, timed in DAC update ticks.
 * Assumes start restarts the period and tick is a one-cycle pulse at the DAC update rate.
 */
module dwg_trap_gen
   import dwg_pkg::*;
(
   // Clock and reset.
   input  wire logic              clk,
   input  wire logic              rst_b,
   // Control.
   input  wire logic              start,
   input  wire logic              run,
   input  wire logic              tick,
   // Shape.
   input  wire logic [DAC_W-1:0]  levelFirst,
   input  wire logic [DAC_W-1:0]  levelSecond,
   input  wire logic [TIME_W-1:0] delayFirst,
   input  wire logic [TIME_W-1:0] slopeFirst,
   input  wire logic [TIME_W-1:0] delaySecond,
   input  wire logic [TIME_W-1:0] slopeSecond,
   // Result.
   output logic                   inSlope,
   output logic [DAC_W-1:0]       sample
);
   dwg_trap_state_e    state_reg, state_next;
   logic [TIME_W-1:0]  cnt_reg, cnt_next;

   function automatic logic [TIME_W-1:0] spanOf(input dwg_trap_state_e s, input logic [TIME_W-1:0] d1,
         input logic [TIME_W-1:0] s1, input logic [TIME_W-1:0] d2, input logic [TIME_W-1:0] s2);
      logic [TIME_W-1:0] r;
      r = d1;
      case (s)
         DWG_SLOPE1: r = s1;
         DWG_DELAY2: r = d2;
         DWG_SLOPE2: r = s2;
         default:    r = d1;
      endcase
      return r;
   endfunction

   function automatic dwg_trap_state_e succ(input dwg_trap_state_e s);
      dwg_trap_state_e r;
      r = DWG_DELAY1;
      case (s)
         DWG_DELAY1: r = DWG_SLOPE1;
         DWG_SLOPE1: r = DWG_DELAY2;
         DWG_DELAY2: r = DWG_SLOPE2;
         default:    r = DWG_DELAY1;
      endcase
      return r;
   endfunction

   dwg_trap_state_e hop;
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      hop        = succ(state_reg);
      // Zero-length segments are passed over in the same tick, so zero slopes give a square wave.
      for (int i = 0; i < 3; i++) begin
         if (spanOf(hop, delayFirst, slopeFirst, delaySecond, slopeSecond) == '0) begin
            hop = succ(hop);
         end
      end
      if (start) begin
         state_next = DWG_DELAY1;
         cnt_next   = '0;
      end else if (run && tick) begin
         if (cnt_reg + 1'b1 >= spanOf(state_reg, delayFirst, slopeFirst, delaySecond, slopeSecond)) begin
            state_next = hop;
            cnt_next   = '0;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= DWG_DELAY1;
         cnt_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   logic signed [DAC_W:0]          diff;
   logic signed [DAC_W+TIME_W+1:0] ramp;
   always_comb begin
      diff = $signed({1'b0, levelSecond}) - $signed({1'b0, levelFirst});
      ramp = '0;
      sample = levelFirst;
      case (state_reg)
         DWG_SLOPE1: begin
            ramp   = diff * $signed({1'b0, cnt_reg}) / $signed({1'b0, slopeFirst});
            sample = DAC_W'($signed({1'b0, levelFirst}) + ramp);
         end
         DWG_DELAY2: begin
            sample = levelSecond;
         end
         DWG_SLOPE2: begin
            ramp   = diff * $signed({1'b0, cnt_reg}) / $signed({1'b0, slopeSecond});
            sample = DAC_W'($signed({1'b0, levelSecond}) - ramp);
         end
         default: begin
            sample = levelFirst;
         end
      endcase
   end

   assign inSlope = (state_reg == DWG_SLOPE1) || (state_reg == DWG_SLOPE2);
endmodule

// ### dwg_dac_model.sv
/*
 * Behavioural DAC seen from the generator: latches the code on each update strobe and
 * keeps the last code, the number of updates and the clock count between the last two.
 * Assumes the strobe is a one-cycle pulse in the clk domain, qualified by rst_b.
 */
module dwg_dac_model
   import dwg_pkg::*;
(
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Sample stream.
   input  wire logic [DAC_W-1:0] code,
   input  wire logic             update,
   // Observed state.
   output logic      [DAC_W-1:0] heldCode,
   output int                    updCount,
   output int                    lastGap
);
   timeunit 1ns;
   timeprecision 1ps;
   int sinceUpd;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         heldCode <= '0;
         updCount <= 0;
         lastGap  <= 0;
         sinceUpd <= 0;
      end else if (update === 1'b1) begin
         heldCode <= code;
         updCount <= updCount + 1;
         lastGap  <= sinceUpd + 1;
         sinceUpd <= 0;
      end else begin
         sinceUpd <= sinceUpd + 1;
      end
   end
endmodule

// ### dwg_wavegen_bench.sv
/*
 * Self-checking bench for the waveform generator: APB read and write tasks, a DAC model on
 * each output, and sequences for direct, sine, stop, square and ramp operation.
 * Assumes the slave answers without wait states but still waits for pready.
 */
module dwg_wavegen_bench
   import dwg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk, rst_b, psel, penable, pwrite, pready, pslverr, fastUpd, lpUpd;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata;
   logic [DAC_W-1:0]  fastCode, lpCode, fastHeld, lpHeld;
   logic [DAC_W-1:0]  codes [24];
   int                fastCnt, lpCnt, fastGap, lpGap, failCount, cmpCount, hi, ok, c0;
   int                gaps [24];

   dwg_wavegen i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fastDacCode(fastCode), .fastDacUpdate(fastUpd), .lpDacCode(lpCode), .lpDacUpdate(lpUpd));
   dwg_dac_model i_fast (.clk(clk), .rst_b(rst_b), .code(fastCode), .update(fastUpd),
      .heldCode(fastHeld), .updCount(fastCnt), .lastGap(fastGap));
   dwg_dac_model i_lp (.clk(clk), .rst_b(rst_b), .code(lpCode), .update(lpUpd),
      .heldCode(lpHeld), .updCount(lpCnt), .lastGap(lpGap));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmpCount++;
      if (got !== exp) begin
         failCount++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Called just after a rising edge; leaves one idle cycle so strobes never double up.
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] expD, input logic expE);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk("read data", expD, q);
      chk("read error", {31'h0, expE}, {31'h0, e});
   endtask

   // Gathers n updates from one DAC with the gap before each.
   task automatic grab(input bit lp, input int n);
      int c, k;
      for (int i = 0; i < n; i++) begin
         c = lp ? lpCnt : fastCnt;
         k = 0;
         while ((lp ? lpCnt : fastCnt) == c && k < 2000) begin
            @(posedge clk);
            k++;
         end
         chk("update wait", 32'h0, {31'h0, k >= 2000});
         codes[i] = lp ? lpHeld : fastHeld;
         gaps[i]  = lp ? lpGap : fastGap;
      end
   endtask

   task automatic tallyAndFinish();
      $display("Comparisons %0d, mismatches %0d", cmpCount, failCount);
      if (failCount == 0 && cmpCount > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge clk);
      failCount++;
      tallyAndFinish();
   end

   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
      failCount = 0;
      cmpCount  = 0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(OFF_WG_CONFIG, 32'h30, 1'b0);
      rd(16'h2034, 32'h0, 1'b1);
      wr(OFF_FAST_DATA, 32'habc);
      grab(0, 1);
      chk("direct code", 32'habc, codes[0]);
      wr(OFF_SINE_OFFSET, 32'h10000000);
      wr(OFF_WG_CONFIG, 32'h34);
      grab(0, 3);
      chk("sine start code", 32'hffd, codes[2]);
      chk("sine tick gap", 1, gaps[2] >= 15 && gaps[2] <= 16);
      wr(OFF_FREQ_WORD, 32'h04000000);
      wr(OFF_SINE_OFFSET, 32'h12000000);
      wr(OFF_WG_CONFIG, 32'h34);
      // The first update may still come from the source that ran before the restart.
      grab(0, 18);
      chk("sine direction", 1, codes[2] < codes[1]);
      chk("sine half turn", 1, codes[9] !== codes[1]);
      chk("sine period", codes[1], codes[17]);
      wr(OFF_FRONT_END, 32'h0);
      repeat (20) @(posedge clk);
      c0 = fastCnt;
      hi = fastHeld;
      repeat (400) @(posedge clk);
      chk("stopped count", c0, fastCnt);
      chk("stopped hold", hi, fastHeld);
      wr(OFF_LEVEL_FIRST, 32'h100);
      wr(OFF_LEVEL_SECND, 32'h700);
      wr(OFF_DELAY_FIRST, 32'h2);
      wr(OFF_DELAY_SECND, 32'h3);
      wr(OFF_WG_CONFIG, 32'h36);
      grab(0, 11);
      hi = 0;
      ok = 0;
      for (int i = 1; i < 11; i++) begin
         hi += (codes[i] === 12'h700);
         ok += (codes[i] === 12'h100 || codes[i] === 12'h700) + (gaps[i] >= 781 && gaps[i] <= 782);
      end
      chk("square high count", 6, hi);
      chk("square codes and gaps", 20, ok);
      wr(OFF_LP_CONTROL, 32'h40);
      wr(OFF_LEVEL_FIRST, 32'h0);
      wr(OFF_LEVEL_SECND, 32'h400);
      wr(OFF_DELAY_FIRST, 32'h1);
      wr(OFF_DELAY_SECND, 32'h1);
      wr(OFF_SLOPE_FIRST, 32'h4);
      wr(OFF_SLOPE_SECND, 32'h4);
      wr(OFF_WG_CONFIG, 32'h36);
      c0 = fastCnt;
      grab(1, 21);
      hi = 0;
      ok = 0;
      for (int i = 1; i < 11; i++) begin
         hi += (codes[i] > 12'h0 && codes[i] < 12'h400);
         ok += (codes[i] === codes[i + 10]);
      end
      chk("ramp mid samples", 6, hi);
      chk("ramp period", 10, ok);
      chk("fast idle while routed", c0, fastCnt);
      tallyAndFinish();
   end
endmodule
